// ---- rtl/hdpm_pkg.sv ----
// Purpose: Shared constants and types of the host data pin function mux.
// Assumes: One 25 MHz core clock, word registers on an AHB-Lite slave.
// Notes:   Modes are one-hot; bus pin positions are named once here.
package hdpm_pkg;

    localparam int          BUS_W            = 16;
    localparam int          ADDR_W           = 8;

    localparam logic [7:0]  ADDR_MODE        = 8'h00;
    localparam logic [7:0]  ADDR_RDATA       = 8'h04;
    localparam logic [7:0]  ADDR_CTRL        = 8'h08;
    localparam logic [7:0]  ADDR_WDATA       = 8'h0C;
    localparam logic [7:0]  ADDR_SERIAL      = 8'h10;

    localparam int          CTRL_DRIVE_BIT   = 0;
    localparam int          CTRL_CAPTURE_BIT = 1;
    localparam int          CTRL_UPPER_BIT   = 2;
    localparam int          SER_LANE_A_BIT   = 0;
    localparam int          SER_LANE_B_BIT   = 1;
    localparam int          SER_INPUT_BIT    = 8;

    localparam int          MODE_VALID_BIT   = 0;
    localparam int          MODE_IFACE_BIT   = 1;
    localparam int          MODE_RNG_LSB     = 2;
    localparam int          MODE_BYTE_BIT    = 4;
    localparam int          MODE_LANE_BIT    = 5;
    localparam int          MODE_CSUM_BIT    = 6;
    localparam int          MODE_CODE_LSB    = 8;

    localparam int          PIN_LANE_STRAP   = 4;
    localparam int          PIN_CSUM_STRAP   = 5;
    localparam int          PIN_BYTE_STRAP   = 9;
    localparam int          PIN_PROG_IN      = 10;
    localparam int          PIN_LANE_B       = 11;
    localparam int          PIN_LANE_A       = 12;

    localparam logic [1:0]  RANGE_SOFTWARE   = 2'h0;
    localparam logic [15:0] OE_N_ALL_OFF     = 16'hFFFF;
    localparam logic [15:0] OE_N_LOW_BYTE    = 16'hFF00;
    localparam logic [15:0] RST_RDATA        = 16'h0000;
    localparam logic [15:0] RST_WDATA        = 16'h0000;
    localparam logic [2:0]  RST_CTRL         = 3'h0;
    localparam logic [1:0]  RST_SERIAL       = 2'h0;
    localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;

    typedef enum logic [6:0] {
        MODE_NONE    = 7'h01,
        MODE_SW_PAR  = 7'h02,
        MODE_HW_PAR  = 7'h04,
        MODE_SW_BYTE = 7'h08,
        MODE_HW_BYTE = 7'h10,
        MODE_SW_SER  = 7'h20,
        MODE_HW_SER  = 7'h40
    } hdpm_mode_e;

endpackage : hdpm_pkg

// ---- rtl/hdpm_strap_if.sv ----
// Purpose: Carries synchronised pin levels to the strap latch and latched straps back.
// Assumes: Both ends run on the core clock.
// Notes:   Pin levels here are already past two flip-flops.
interface hdpm_strap_if;
    logic        pin_sel;
    logic [1:0]  pin_rng;
    logic [15:0] pin_bus;
    logic        valid;
    logic        iface_sel;
    logic [1:0]  rng;
    logic        byte_sel;
    logic        lane_split;
    logic        checksum;

    modport latch (input pin_sel, pin_rng, pin_bus,
                   output valid, iface_sel, rng, byte_sel, lane_split, checksum);
    modport user  (output pin_sel, pin_rng, pin_bus,
                   input valid, iface_sel, rng, byte_sel, lane_split, checksum);
endinterface : hdpm_strap_if

// ---- rtl/hdpm_strap_latch.sv ----
// Purpose: Captures the mode selector, range-mode pins and bus straps at full-reset release.
// Assumes: Reset is synchronous and active high; pin levels arrive synchronised.
// Notes:   Captured values hold until the next full reset.
module hdpm_strap_latch
    import hdpm_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    hdpm_strap_if.latch sif
);

    typedef struct packed {
        logic       pend;
        logic       valid;
        logic       iface_sel;
        logic [1:0] rng;
        logic       byte_sel;
        logic       lane_split;
        logic       checksum;
    } hdpm_latch_s;

    hdpm_latch_s q;
    hdpm_latch_s d;

    always_comb begin
        d = q;
        if (q.pend) begin
            // The first cycle after release takes the straps once.
            d.pend      = 1'b0;
            d.valid     = 1'b1;
            d.iface_sel = sif.pin_sel;
            d.rng       = sif.pin_rng;
            d.byte_sel  = sif.pin_sel & sif.pin_bus[PIN_BYTE_STRAP];
            d.lane_split = sif.pin_sel & ~sif.pin_bus[PIN_BYTE_STRAP]
                           & sif.pin_bus[PIN_LANE_STRAP];
            d.checksum  = sif.pin_sel & ~sif.pin_bus[PIN_BYTE_STRAP]
                          & sif.pin_bus[PIN_CSUM_STRAP];
        end
        if (rst) begin
            d = '0;
            d.pend = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        q <= d;
    end

    assign sif.valid      = q.valid;
    assign sif.iface_sel  = q.iface_sel;
    assign sif.rng        = q.rng;
    assign sif.byte_sel   = q.byte_sel;
    assign sif.lane_split = q.lane_split;
    assign sif.checksum   = q.checksum;

    a_strap_hold: assert property (@(posedge clk) disable iff (rst)
        q.valid && $past(q.valid) |-> $stable({q.iface_sel, q.rng, q.byte_sel}))
        else $error("Latched straps changed without a full reset.");

    a_latch_release: assert property (@(posedge clk)
        rst ##1 !rst |=> q.valid && q.rng == $past(sif.pin_rng, 1))
        else $error("Straps not taken at the first edge after release.");

endmodule : hdpm_strap_latch

// ---- rtl/hdpm_top.sv ----
// Purpose: Steers the sixteen shared data-bus pins by the modes latched at full reset.
// Assumes: Registers reached over AHB-Lite; pins and mode inputs are asynchronous.
// Notes:   Output enables are low while a pin is driven.
//
// Behaviour
// - Software parallel: all pins write and read.
// - Hardware parallel: all pins output only.
// - Software byte: low byte writes and reads.
// - Hardware byte: low byte output only.
// - Bit nine at reset selects byte/serial.
// - Byte strap changes ignored until reset.
// - Bit four latched: one or two lanes.
// - Bit five latched: checksum word enable.
// - Software serial: bit ten programs device.
// - Serial: bit twelve lane A, eleven B.
// - Byte/serial: bit nine input only.
// - Selector latched at reset: parallel or not.
// - Range pins latched: 00 means software.
//
// Design decisions made here: the address map and the AHB-Lite register port.
module hdpm_top
    import hdpm_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic [31:0]      HRDATA,
    input  wire logic        INTERFACE_SELECTOR,
    input  wire logic [1:0]  RANGE_MODE_PINS,
    input  wire logic [15:0] DB_IN,
    output logic [15:0]      DB_OUT,
    output logic [15:0]      DB_OE_N,
    output logic             LANE_SPLIT,
    output logic             CHECKSUM_EN
);

    typedef struct packed {
        logic [1:0]        sel_sync;
        logic [1:0][1:0]   rng_sync;
        logic [1:0][15:0]  bus_sync;
        hdpm_mode_e        mode;
        logic              wr_pend;
        logic [7:0]        wr_addr;
        logic [15:0]       rdata;
        logic [15:0]       wdata;
        logic [2:0]        ctrl;
        logic [1:0]        serial;
        logic [31:0]       hrdata;
        logic              hreadyout;
        logic              hresp;
        logic [15:0]       db_out;
        logic [15:0]       db_oe_n;
        logic              lane_split;
        logic              checksum;
    } hdpm_top_s;

    hdpm_top_s    q;
    hdpm_top_s    d;
    hdpm_strap_if sif ();

    function automatic hdpm_mode_e decode_mode(input logic valid, input logic sel,
                                               input logic [1:0] rng, input logic bsel);
        logic sw;
        sw = (rng == RANGE_SOFTWARE);
        if (!valid) begin
            decode_mode = MODE_NONE;
        end else if (!sel) begin
            decode_mode = sw ? MODE_SW_PAR : MODE_HW_PAR;
        end else if (bsel) begin
            decode_mode = sw ? MODE_SW_BYTE : MODE_HW_BYTE;
        end else begin
            decode_mode = sw ? MODE_SW_SER : MODE_HW_SER;
        end
    endfunction : decode_mode

    assign sif.pin_sel = q.sel_sync[1];
    assign sif.pin_rng = q.rng_sync[1];
    assign sif.pin_bus = q.bus_sync[1];

    hdpm_strap_latch u_latch (
        .clk (CORE_CLK),
        .rst (RST),
        .sif (sif)
    );

    logic        addr_ok;
    logic        take;
    logic [31:0] rd_word;
    logic        drive;

    always_comb begin
        addr_ok = (HADDR[31:ADDR_W] == '0) && (HADDR[1:0] == 2'h0);
        take    = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
        drive   = q.ctrl[CTRL_DRIVE_BIT];
        rd_word = UNMAPPED_READ;
        if (addr_ok) begin
            unique case (HADDR[ADDR_W-1:0])
                ADDR_MODE: begin
                    rd_word[MODE_VALID_BIT] = sif.valid;
                    rd_word[MODE_IFACE_BIT] = sif.iface_sel;
                    rd_word[MODE_RNG_LSB +: 2] = sif.rng;
                    rd_word[MODE_BYTE_BIT] = sif.byte_sel;
                    rd_word[MODE_LANE_BIT] = sif.lane_split;
                    rd_word[MODE_CSUM_BIT] = sif.checksum;
                    rd_word[MODE_CODE_LSB +: 7] = q.mode;
                end
                ADDR_RDATA: rd_word[15:0] = q.rdata;
                ADDR_CTRL: rd_word[2:0] = q.ctrl;
                ADDR_WDATA: rd_word[15:0] = q.wdata;
                ADDR_SERIAL: begin
                    rd_word[1:0] = q.serial;
                    rd_word[SER_INPUT_BIT] = (q.mode == MODE_SW_SER)
                                             & q.bus_sync[1][PIN_PROG_IN];
                end
                default: rd_word = UNMAPPED_READ;
            endcase
        end

        d = q;
        d.sel_sync = {q.sel_sync[0], INTERFACE_SELECTOR};
        d.rng_sync = {q.rng_sync[0], RANGE_MODE_PINS};
        d.bus_sync = {q.bus_sync[0], DB_IN};
        d.mode     = decode_mode(sif.valid, sif.iface_sel, sif.rng, sif.byte_sel);

        // Host programming words are only taken in software modes.
        d.ctrl[CTRL_CAPTURE_BIT] = 1'b0;
        if (q.ctrl[CTRL_CAPTURE_BIT] && !drive) begin
            if (q.mode == MODE_SW_PAR) begin
                d.wdata = q.bus_sync[1];
            end else if (q.mode == MODE_SW_BYTE) begin
                d.wdata = {8'h00, q.bus_sync[1][7:0]};
            end
        end

        // Bus data phase: writes land one cycle after the address phase.
        d.hrdata  = take && !HWRITE ? rd_word : UNMAPPED_READ;
        d.wr_pend = take && HWRITE && addr_ok;
        d.wr_addr = HADDR[ADDR_W-1:0];
        d.hreadyout = 1'b1;
        d.hresp     = 1'b0;
        if (q.wr_pend) begin
            unique case (q.wr_addr)
                ADDR_RDATA:  d.rdata  = HWDATA[15:0];
                ADDR_CTRL:   d.ctrl   = HWDATA[2:0];
                ADDR_SERIAL: d.serial = HWDATA[1:0];
                default:     d.ctrl   = d.ctrl;
            endcase
        end

        // Pin drivers follow the latched mode.
        d.db_oe_n = OE_N_ALL_OFF;
        d.db_out  = 16'h0000;
        unique case (q.mode)
            MODE_SW_PAR, MODE_HW_PAR: begin
                if (drive) begin
                    d.db_oe_n = 16'h0000;
                    d.db_out  = q.rdata;
                end
            end
            MODE_SW_BYTE, MODE_HW_BYTE: begin
                if (drive) begin
                    d.db_oe_n = OE_N_LOW_BYTE;
                    d.db_out[7:0] = q.ctrl[CTRL_UPPER_BIT] ? q.rdata[15:8] : q.rdata[7:0];
                end
            end
            MODE_SW_SER, MODE_HW_SER: begin
                d.db_oe_n[PIN_LANE_A] = 1'b0;
                d.db_oe_n[PIN_LANE_B] = 1'b0;
                d.db_out[PIN_LANE_A]  = q.serial[SER_LANE_A_BIT];
                d.db_out[PIN_LANE_B]  = sif.lane_split & q.serial[SER_LANE_B_BIT];
            end
            MODE_NONE: d.db_oe_n = OE_N_ALL_OFF;
        endcase
        d.lane_split = sif.lane_split;
        d.checksum   = sif.checksum;

        if (RST) begin
            d.mode       = MODE_NONE;
            d.wr_pend    = 1'b0;
            d.wr_addr    = '0;
            d.rdata      = RST_RDATA;
            d.wdata      = RST_WDATA;
            d.ctrl       = RST_CTRL;
            d.serial     = RST_SERIAL;
            d.hrdata     = UNMAPPED_READ;
            d.hreadyout  = 1'b1;
            d.hresp      = 1'b0;
            d.db_out     = 16'h0000;
            d.db_oe_n    = OE_N_ALL_OFF;
            d.lane_split = 1'b0;
            d.checksum   = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        q <= d;
    end

    assign HREADYOUT   = q.hreadyout;
    assign HRESP       = q.hresp;
    assign HRDATA      = q.hrdata;
    assign DB_OUT      = q.db_out;
    assign DB_OE_N     = q.db_oe_n;
    assign LANE_SPLIT  = q.lane_split;
    assign CHECKSUM_EN = q.checksum;

    a_par_sw_drive: assert property (@(posedge CORE_CLK) disable iff (RST)
        q.mode == MODE_SW_PAR && drive |=> DB_OE_N == 16'h0000)
        else $error("Software parallel read did not drive all pins.");

    a_hw_par_nowrite: assert property (@(posedge CORE_CLK) disable iff (RST)
        q.mode == MODE_HW_PAR && $stable(q.mode) |=> $stable(q.wdata))
        else $error("Hardware parallel mode accepted a programming word.");

    a_byte_sw_capture: assert property (@(posedge CORE_CLK) disable iff (RST)
        q.mode == MODE_SW_BYTE && q.ctrl[CTRL_CAPTURE_BIT] && !drive
        |=> q.wdata == {8'h00, $past(q.bus_sync[1][7:0])})
        else $error("Software byte mode lost a programming byte.");

    a_byte_hw_drive: assert property (@(posedge CORE_CLK) disable iff (RST)
        q.mode == MODE_HW_BYTE |=> DB_OE_N[15:8] == 8'hFF && $stable(q.wdata))
        else $error("Hardware byte mode drove upper pins or took a write.");

    a_ser_lanes_on: assert property (@(posedge CORE_CLK) disable iff (RST)
        (q.mode == MODE_SW_SER || q.mode == MODE_HW_SER)
        |=> !DB_OE_N[PIN_LANE_A] && !DB_OE_N[PIN_LANE_B]
            && DB_OUT[PIN_LANE_A] == $past(q.serial[SER_LANE_A_BIT]))
        else $error("Serial lanes not driven on bits twelve and eleven.");

    a_ser_single_lane: assert property (@(posedge CORE_CLK) disable iff (RST)
        (q.mode == MODE_SW_SER || q.mode == MODE_HW_SER) && !sif.lane_split
        |=> !DB_OUT[PIN_LANE_B])
        else $error("Lane B carried data with one lane selected.");

    a_bit9_input: assert property (@(posedge CORE_CLK) disable iff (RST)
        sif.valid && sif.iface_sel ##1 sif.iface_sel |-> DB_OE_N[PIN_BYTE_STRAP])
        else $error("Bit nine driven in byte or serial mode.");

    a_tie_low_off: assert property (@(posedge CORE_CLK) disable iff (RST)
        q.mode == MODE_HW_SER
        |=> DB_OE_N[10:0] == 11'h7FF && DB_OE_N[15:13] == 3'h7)
        else $error("A strap or tie-low pin was driven in serial mode.");

    a_mode_decode: assert property (@(posedge CORE_CLK) disable iff (RST)
        sif.valid && !sif.iface_sel && sif.rng == RANGE_SOFTWARE
        |=> q.mode == MODE_SW_PAR)
        else $error("Parallel software mode not chosen from the latched pins.");

endmodule : hdpm_top

// ---- verif/hdpm_host_model.sv ----
// Purpose: Host side of the shared data-bus pins, with straps and tie-low pins.
// Assumes: Device output enables are low while the device drives a pin.
// Notes:   Pins that no party drives show a pattern that changes every cycle.
module hdpm_host_model
    import hdpm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sel,
    input  wire logic        byte_strap,
    input  wire logic        bit9_level,
    input  wire logic        lane_strap,
    input  wire logic        csum_strap,
    input  wire logic        sw_mode,
    input  wire logic        host_en,
    input  wire logic [15:0] host_data,
    input  wire logic        prog_bit,
    input  wire logic [15:0] dev_out,
    input  wire logic [15:0] dev_oe_n,
    output logic [15:0]      bus
);
    logic        tog_q;
    logic [15:0] host_v;

    initial tog_q = 1'b0;
    always @(posedge clk) tog_q <= ~tog_q;

    always_comb begin
        host_v = host_en ? host_data : (16'hA5A5 ^ {16{tog_q}});
        if (sel) begin
            host_v[8] = 1'b0;
            host_v[PIN_BYTE_STRAP] = bit9_level;
            if (byte_strap) begin
                host_v[12:10] = 3'h0;
            end else begin
                host_v[3:0] = 4'h0;
                host_v[7:6] = 2'h0;
                host_v[PIN_LANE_STRAP] = lane_strap;
                host_v[PIN_CSUM_STRAP] = csum_strap;
                host_v[PIN_PROG_IN] = sw_mode ? prog_bit : 1'b0;
            end
        end
        bus = (~dev_oe_n & dev_out) | (dev_oe_n & host_v);
    end
endmodule : hdpm_host_model

// ---- verif/hdpm_tb_top.sv ----
// Purpose: Mode-by-mode check of pin steering, straps and registers.
// Assumes: Zero-wait AHB-Lite slave; pin levels pass two synchronising flops.
// Notes:   Each mode is entered by a full reset with its own strap levels.
module hdpm_tb_top
    import hdpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        CORE_CLK = 1'b0;
    logic        RST      = 1'b1;
    logic        HSEL     = 1'b0;
    logic        HWRITE   = 1'b0;
    logic [1:0]  HTRANS   = 2'h0;
    logic [31:0] HADDR    = 32'h0;
    logic [31:0] HWDATA   = 32'h0;
    logic        HREADYOUT;
    logic        HRESP;
    logic [31:0] HRDATA;
    logic        sel = 1'b0, bstrap = 1'b0, b9 = 1'b0, lane = 1'b0, csum = 1'b0;
    logic        hen = 1'b0, pbit = 1'b0;
    logic [1:0]  rng = 2'h0;
    logic [15:0] hdata = 16'h0;
    logic [15:0] db_in, db_out, db_oe_n;
    logic        lane_split, csum_en;
    int          n_fail = 0;
    int          tests_run = 0;
    logic [5:0]  cfg [6] = '{6'h00, 6'h08, 6'h24, 6'h34, 6'h22, 6'h39};

    always #20 CORE_CLK = ~CORE_CLK;

    // Bus answers are taken mid-cycle so that the edge that ends a phase sees settled values.
    logic [31:0] hrdata_n = 32'h0;
    logic        hresp_n  = 1'b0;
    logic        hrdy_n   = 1'b0;
    always @(negedge CORE_CLK) begin
        hrdata_n <= HRDATA;
        hresp_n  <= HRESP;
        hrdy_n   <= HREADYOUT;
    end

    hdpm_top hdpm_top_inst (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA), .INTERFACE_SELECTOR(sel),
        .RANGE_MODE_PINS(rng), .DB_IN(db_in), .DB_OUT(db_out), .DB_OE_N(db_oe_n),
        .LANE_SPLIT(lane_split), .CHECKSUM_EN(csum_en));

    hdpm_host_model hdpm_host_model_inst (.clk(CORE_CLK), .sel(sel), .byte_strap(bstrap),
        .bit9_level(b9), .lane_strap(lane), .csum_strap(csum), .sw_mode(rng == 2'h0),
        .host_en(hen), .host_data(hdata), .prog_bit(pbit), .dev_out(db_out),
        .dev_oe_n(db_oe_n), .bus(db_in));

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge CORE_CLK);
            k++;
        end while (hrdy_n !== 1'b1 && k < 64);
        if (hrdy_n !== 1'b1) begin
            chk("hready", 32'h1, {31'h0, hrdy_n});
            test_done();
        end
    endtask : wait_rdy

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge CORE_CLK);
        HSEL   <= 1'b1;
        HADDR  <= {24'h0, a};
        HTRANS <= HTRANS_NONSEQ;
        HWRITE <= w;
        wait_rdy();
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_rdy();
        r = hrdata_n;
        chk("hresp", 32'h0, {31'h0, hresp_n});
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0, x);
        chk(nm, e, x);
    endtask : rd

    initial begin
        logic [31:0] em;
        logic [6:0]  code;
        logic        sw, ser;
        for (int m = 0; m < 6; m++) begin
            @(posedge CORE_CLK);
            {sel, rng, bstrap, lane, csum} <= cfg[m];
            b9   <= cfg[m][2];
            hen  <= 1'b0;
            pbit <= 1'b0;
            RST  <= 1'b1;
            repeat (16) @(posedge CORE_CLK);
            RST <= 1'b0;
            repeat (4) @(posedge CORE_CLK);
            sw   = (cfg[m][4:3] == 2'h0);
            ser  = cfg[m][5] & ~cfg[m][2];
            code = !cfg[m][5] ? (sw ? MODE_SW_PAR : MODE_HW_PAR) :
                   cfg[m][2] ? (sw ? MODE_SW_BYTE : MODE_HW_BYTE) :
                   (sw ? MODE_SW_SER : MODE_HW_SER);
            em = {17'h0, code, 1'b0, cfg[m][0] & ser, cfg[m][1] & ser,
                  cfg[m][2] & cfg[m][5], cfg[m][4:3], cfg[m][5], 1'b1};
            rd(ADDR_MODE, em, "mode");
            chk("lane_split", {31'h0, cfg[m][1] & ser}, {31'h0, lane_split});
            chk("checksum_en", {31'h0, cfg[m][0] & ser}, {31'h0, csum_en});
            rd(ADDR_RDATA, 32'h0, "rdata_rst");
            rd(ADDR_CTRL, 32'h0, "ctrl_rst");
            rd(ADDR_WDATA, 32'h0, "wdata_rst");
            rd(ADDR_SERIAL, 32'h0, "serial_rst");
            @(posedge CORE_CLK);
            b9 <= ~b9;
            repeat (4) @(posedge CORE_CLK);
            wr(ADDR_MODE, 32'hFFFF);
            rd(ADDR_MODE, em, "mode_held");
            chk("oe_idle", ser ? 32'h07FF : 32'hFFFF,
                {16'h0, db_oe_n & (ser ? 16'h1FFF : 16'hFFFF)});
            wr(ADDR_RDATA, 32'h5AC3);
            rd(ADDR_RDATA, 32'h5AC3, "rdata");
            @(posedge CORE_CLK);
            hen   <= 1'b1;
            hdata <= 16'hC3A5;
            repeat (3) @(posedge CORE_CLK);
            wr(ADDR_CTRL, 32'h2);
            repeat (2) @(posedge CORE_CLK);
            hen <= 1'b0;
            em = !sw ? 32'h0 : !cfg[m][5] ? 32'hC3A5 : cfg[m][2] ? 32'h00A5 : 32'h0;
            rd(ADDR_WDATA, em, "capture");
            wr(ADDR_CTRL, 32'h1);
            repeat (3) @(posedge CORE_CLK);
            if (!cfg[m][5]) begin
                chk("oe_par", 32'h0, {16'h0, db_oe_n});
                chk("out_par", 32'h5AC3, {16'h0, db_out});
            end else if (cfg[m][2]) begin
                chk("oe_byte", 32'hFF00, {16'h0, db_oe_n});
                chk("out_lo", 32'hC3, {24'h0, db_out[7:0]});
                wr(ADDR_CTRL, 32'h5);
                repeat (3) @(posedge CORE_CLK);
                chk("out_hi", 32'h5A, {24'h0, db_out[7:0]});
            end else begin
                chk("oe_ser", 32'h07FF, {16'h0, db_oe_n & 16'h1FFF});
                wr(ADDR_SERIAL, 32'h3);
                @(posedge CORE_CLK);
                pbit <= sw;
                repeat (4) @(posedge CORE_CLK);
                chk("lanes", {30'h0, 1'b1, cfg[m][1]}, {30'h0, db_out[12:11]});
                rd(ADDR_SERIAL, {23'h0, sw, 8'h3}, "serial_in");
            end
            if (m == 0) begin
                wr(8'h14, 32'hFFFF);
                rd(8'h14, UNMAPPED_READ, "unmapped");
            end
            $display("mode test %0d done", m);
        end
        test_done();
    end
endmodule : hdpm_tb_top
